// ---- shared/video_port_pkg.sv ----
// constants and types shared by the dual-edge video input port
package video_port_pkg;
  localparam int PIXEL_W = 8;
  localparam int PAIR_W = 16;
  localparam int BUF_DEPTH = 2;
  localparam int COUNT_W = 2;
  localparam int HS_LEN_W = 8;
  localparam logic [COUNT_W-1:0] COUNT_FULL = 2'h2;
  localparam logic [COUNT_W-1:0] COUNT_ONE = 2'h1;
  localparam logic [COUNT_W-1:0] COUNT_ZERO = 2'h0;
  localparam logic [HS_LEN_W-1:0] HS_LEN_ZERO = 8'h00;
  localparam logic [HS_LEN_W-1:0] HS_LEN_LAST = 8'h01;
  localparam logic [PIXEL_W-1:0] BYTE_RESET = 8'h00;
  // serial control bus slave addresses chosen by the strap
  localparam logic [7:0] SLAVE_ADDR_LOW = 8'h88;
  localparam logic [7:0] SLAVE_ADDR_HIGH = 8'h8C;
  // nominal rate of the line-locked master clock
  localparam int MASTER_CLOCK_MHZ = 27;
  localparam int PORT_WORD_MHZ = 54;
  // what the vertical raster pin drives when it is an output
  localparam logic [1:0] VERT_SEL_VSYNC = 2'h0;
  localparam logic [1:0] VERT_SEL_FIELD = 2'h1;
  localparam logic [1:0] VERT_SEL_FIELD_SEQUENCE_INDICATOR = 2'h2;
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_PULSE = 2'b01
  } hs_state_t;
endpackage : video_port_pkg

// ---- src/dual_edge_video_input_port.sv ----
// dual-edge pixel capture, route switch, buffer and raster pins
`timescale 1ns/1ns
module dual_edge_video_input_port (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic [7:0] multiplexed_pixel_bus,
  input wire logic pixel_valid,
  output logic pixel_ready,
  input wire logic edge_route_select_a,
  input wire logic edge_route_select_b,
  output logic [7:0] enc_byte,
  output logic [7:0] rgb_byte,
  output logic out_valid,
  input wire logic out_ready,
  input wire logic raster_ctrl_vertical_pin_in,
  output logic raster_ctrl_vertical_pin_out,
  output logic raster_ctrl_vertical_pin_oe,
  input wire logic vert_drive_enable,
  input wire logic [1:0] vert_out_select,
  input wire logic vertical_sync_pulse,
  input wire logic field_indicator,
  input wire logic field_sequence_indicator,
  output logic vertical_in_sync,
  input wire logic raster_ctrl_horizontal_pin_in,
  output logic raster_ctrl_horizontal_pin_out,
  output logic raster_ctrl_horizontal_pin_oe,
  input wire logic horz_drive_enable,
  input wire logic [7:0] hsync_length,
  input wire logic line_start,
  output logic horizontal_in_sync,
  input wire logic bus_address_select,
  output logic [7:0] slave_address,
  input wire logic start_detected,
  output logic bus_wait_start,
  input wire logic realtime_control_input,
  output logic realtime_control_sync
);
  logic [7:0] rise_cap;
  logic [7:0] fall_cap;
  logic [7:0] rise_sync;
  logic [7:0] fall_sync;
  logic valid_cap;
  logic valid_sync;
  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  logic addr_latched;
  logic [1:0] strap_age;
  logic [7:0] enc_src;
  logic [7:0] rgb_src;
  logic [15:0] buf_mem [video_port_pkg::BUF_DEPTH];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] fill;
  logic push;
  logic pop;
  video_port_pkg::hs_state_t hs_state;
  logic [7:0] hs_count;

  // rising-edge capture of the pin bus, first stage only
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rise_cap <= video_port_pkg::BYTE_RESET;
      valid_cap <= 1'b0;
    end else if (ce) begin
      rise_cap <= multiplexed_pixel_bus;
      valid_cap <= pixel_valid;
    end
  end

  // falling-edge capture gives the second interleaved stream
  always_ff @(negedge sys_clk) begin
    if (!reset_n) begin
      fall_cap <= video_port_pkg::BYTE_RESET;
    end else if (ce) begin
      fall_cap <= multiplexed_pixel_bus;
    end
  end

  // retime both bytes onto the rising edge; half a cycle of margin for fall
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rise_sync <= video_port_pkg::BYTE_RESET;
      fall_sync <= video_port_pkg::BYTE_RESET;
      valid_sync <= 1'b0;
    end else if (ce) begin
      rise_sync <= rise_cap;
      fall_sync <= fall_cap;
      valid_sync <= valid_cap;
    end
  end

  // cross switch: a picks the encoder source, b picks the rgb source
  always_comb begin
    enc_src = edge_route_select_a ? fall_sync : rise_sync;
    rgb_src = edge_route_select_b ? rise_sync : fall_sync;
  end

  // two-entry buffer so a stall downstream loses no pair
  assign pixel_ready = (fill != video_port_pkg::COUNT_FULL);
  assign out_valid = (fill != video_port_pkg::COUNT_ZERO);
  assign push = ce && valid_sync && pixel_ready;
  assign pop = ce && out_valid && out_ready;
  assign enc_byte = buf_mem[rd_ptr][15:8];
  assign rgb_byte = buf_mem[rd_ptr][7:0];

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      buf_mem[0] <= {video_port_pkg::BYTE_RESET, video_port_pkg::BYTE_RESET};
      buf_mem[1] <= {video_port_pkg::BYTE_RESET, video_port_pkg::BYTE_RESET};
      wr_ptr <= 1'b0;
    end else if (push) begin
      buf_mem[wr_ptr] <= {enc_src, rgb_src};
      wr_ptr <= ~wr_ptr;
    end
  end

  // read side and occupancy
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rd_ptr <= 1'b0;
      fill <= video_port_pkg::COUNT_ZERO;
    end else begin
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      if (push && !pop) begin
        fill <= fill + video_port_pkg::COUNT_ONE;
      end else if (pop && !push) begin
        fill <= fill - video_port_pkg::COUNT_ONE;
      end
    end
  end

  // two-flop synchronisers for the slow pins
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pin_meta <= 5'h00;
      pin_sync <= 5'h00;
    end else if (ce) begin
      pin_meta <= {raster_ctrl_vertical_pin_in, raster_ctrl_horizontal_pin_in,
                   bus_address_select, realtime_control_input, 1'b0};
      pin_sync <= pin_meta;
    end
  end
  assign vertical_in_sync = pin_sync[4];
  assign horizontal_in_sync = pin_sync[3];
  assign realtime_control_sync = pin_sync[1];

  // strap is caught once both synchroniser stages hold it, not reset zero
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      strap_age <= video_port_pkg::COUNT_ZERO;
      addr_latched <= 1'b0;
      slave_address <= video_port_pkg::SLAVE_ADDR_LOW;
    end else if (ce && !addr_latched) begin
      strap_age <= strap_age + video_port_pkg::COUNT_ONE;
      addr_latched <= (strap_age == video_port_pkg::COUNT_FULL);
      slave_address <= pin_sync[2] ? video_port_pkg::SLAVE_ADDR_HIGH
                                   : video_port_pkg::SLAVE_ADDR_LOW;
    end
  end

  // receiver waits for a fresh start; reset wins over everything
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      bus_wait_start <= 1'b1;
    end else if (ce && start_detected) begin
      bus_wait_start <= 1'b0;
    end
  end

  // vertical pin: input after reset until driving is asked for
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      raster_ctrl_vertical_pin_oe <= 1'b0;
      raster_ctrl_vertical_pin_out <= 1'b0;
    end else if (ce) begin
      raster_ctrl_vertical_pin_oe <= vert_drive_enable;
      unique case (vert_out_select)
        video_port_pkg::VERT_SEL_VSYNC:
          raster_ctrl_vertical_pin_out <= vertical_sync_pulse;
        video_port_pkg::VERT_SEL_FIELD:
          raster_ctrl_vertical_pin_out <= field_indicator;
        video_port_pkg::VERT_SEL_FIELD_SEQUENCE_INDICATOR:
          raster_ctrl_vertical_pin_out <= field_sequence_indicator;
        default: raster_ctrl_vertical_pin_out <= 1'b0; // code 3 unused
      endcase
    end
  end

  // horizontal pulse generator; a zero length suppresses the pulse
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      hs_state <= video_port_pkg::HS_IDLE;
      hs_count <= video_port_pkg::HS_LEN_ZERO;
      raster_ctrl_horizontal_pin_oe <= 1'b0;
    end else if (ce) begin
      raster_ctrl_horizontal_pin_oe <= horz_drive_enable;
      unique case (hs_state)
        video_port_pkg::HS_IDLE: begin
          if (line_start && horz_drive_enable &&
              hsync_length != video_port_pkg::HS_LEN_ZERO) begin
            hs_state <= video_port_pkg::HS_PULSE;
            hs_count <= hsync_length;
          end
        end
        video_port_pkg::HS_PULSE: begin
          hs_count <= hs_count - video_port_pkg::HS_LEN_LAST;
          if (hs_count == video_port_pkg::HS_LEN_LAST) begin
            hs_state <= video_port_pkg::HS_IDLE;
          end
        end
        default: hs_state <= video_port_pkg::HS_IDLE;
      endcase
    end
  end
  assign raster_ctrl_horizontal_pin_out =
    (hs_state == video_port_pkg::HS_PULSE);

  sequence s_run2;
    ce [*2];
  endsequence
  property p_rise_retimed;
    @(posedge sys_clk) disable iff (!reset_n)
      s_run2 |-> rise_sync == $past(rise_cap);
  endproperty
  a_rise_retimed: assert property (p_rise_retimed)
    else $error("rising byte not retimed");
  property p_enc_route;
    @(posedge sys_clk) disable iff (!reset_n)
      (s_run2 and !edge_route_select_a [*2]) |-> enc_src == $past(rise_cap);
  endproperty
  a_enc_route: assert property (p_enc_route)
    else $error("encoder path not fed by rising stream");
  property p_rgb_swap;
    @(posedge sys_clk) disable iff (!reset_n)
      (s_run2 and edge_route_select_b [*2]) |-> rgb_src == $past(rise_cap);
  endproperty
  a_rgb_swap: assert property (p_rgb_swap)
    else $error("swapped rgb path not fed by rising stream");
  property p_oe_after_reset;
    @(posedge sys_clk) disable iff (!reset_n)
      $rose(reset_n) |-> !raster_ctrl_vertical_pin_oe &&
                         !raster_ctrl_horizontal_pin_oe;
  endproperty
  a_oe_after_reset: assert property (p_oe_after_reset)
    else $error("raster pin driven at reset release");
  property p_wait_start;
    @(posedge sys_clk) disable iff (!reset_n)
      $rose(reset_n) |-> bus_wait_start;
  endproperty
  a_wait_start: assert property (p_wait_start)
    else $error("bus receiver not waiting for start");
  property p_addr;
    @(posedge sys_clk) disable iff (!reset_n)
      $rose(addr_latched) |-> slave_address ==
        ($past(pin_sync[2]) ? video_port_pkg::SLAVE_ADDR_HIGH
                            : video_port_pkg::SLAVE_ADDR_LOW);
  endproperty
  a_addr: assert property (p_addr)
    else $error("slave address does not follow strap");
  property p_hs_len;
    @(posedge sys_clk) disable iff (!reset_n)
      (ce && hs_state == video_port_pkg::HS_PULSE &&
       hs_count == video_port_pkg::HS_LEN_LAST) |=>
        hs_state == video_port_pkg::HS_IDLE;
  endproperty
  a_hs_len: assert property (p_hs_len)
    else $error("hsync pulse overran its length");
  property p_vert_oe;
    @(posedge sys_clk) disable iff (!reset_n)
      (ce && !vert_drive_enable) |=> !raster_ctrl_vertical_pin_oe;
  endproperty
  a_vert_oe: assert property (p_vert_oe)
    else $error("vertical pin driven without enable");
  property p_hold;
    @(posedge sys_clk) disable iff (!reset_n)
      (out_valid && !out_ready) |=> out_valid && $stable(enc_byte) &&
                                   $stable(rgb_byte);
  endproperty
  a_hold: assert property (p_hold)
    else $error("stalled output word changed");
endmodule : dual_edge_video_input_port

// ---- testbench/video_source_model.sv ----
// upstream pixel source: one rise byte and one fall byte per clock
`timescale 1ns/1ns
module video_source_model (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic pop,
  input wire logic [7:0] count,
  output logic [7:0] pixel_bus,
  output logic valid
);
  logic [7:0] sent = 8'h00;
  logic [7:0] popped = 8'h00;
  logic [7:0] k = 8'h00;
  initial pixel_bus = 8'h00;
  initial valid = 1'b0;
  // credits count pairs sent but not yet popped, since ready lags
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      sent <= 8'h00;
      popped <= 8'h00;
    end else begin
      if (valid) sent <= sent + 8'h01;
      if (pop) popped <= popped + 8'h01;
    end
  end
  // rise byte set mid low phase, fall byte mid high phase
  always @(negedge sys_clk) begin
    #25;
    valid = reset_n && sent < count && (sent - popped) < 8'h02;
    k = sent;
    pixel_bus = valid ? 8'h10 + k : ~pixel_bus;
  end
  // idle bus shows the inverse of the last byte, never a stale value
  always @(posedge sys_clk) begin
    #25;
    pixel_bus = valid ? 8'hA0 + k : ~pixel_bus;
  end
endmodule : video_source_model

// ---- testbench/dual_edge_video_input_port_tb.sv ----
// self-checking bench for the dual-edge video input port
`timescale 1ns/1ns
module dual_edge_video_input_port_tb;
  logic sys_clk = 0;
  logic reset_n = 0;
  logic [7:0] bus, enc, rgb, saddr, cnt;
  logic [7:0] h_len = 8'h00;
  logic [7:0] count = 8'h00;
  logic [1:0] v_sel = 2'h0;
  logic pvalid, pready, ovalid, v_out, v_oe, h_out, h_oe, v_sync;
  logic h_sync, wait_st, rt_sync;
  logic sel_a = 0, sel_b = 0, oready = 0, v_ext = 0, h_ext = 0;
  logic v_en = 0, h_en = 0, vs = 0, fi = 0, fsq = 0, line_start = 0;
  logic strap = 0, start = 0, rt_in = 0, run = 1;
  int miscompares = 0, comparisons = 0, j = 0;
  always #50 sys_clk = ~sys_clk;
  video_source_model video_source_model_inst (.sys_clk(sys_clk),
    .reset_n(reset_n), .pop(ovalid & oready), .count(count),
    .pixel_bus(bus), .valid(pvalid));
  dual_edge_video_input_port dual_edge_video_input_port_inst (
    .sys_clk(sys_clk), .reset_n(reset_n), .ce(run),
    .multiplexed_pixel_bus(bus), .pixel_valid(pvalid),
    .pixel_ready(pready), .edge_route_select_a(sel_a),
    .edge_route_select_b(sel_b), .enc_byte(enc), .rgb_byte(rgb),
    .out_valid(ovalid), .out_ready(oready),
    .raster_ctrl_vertical_pin_in(v_oe ? v_out : v_ext),
    .raster_ctrl_vertical_pin_out(v_out), .raster_ctrl_vertical_pin_oe(v_oe),
    .vert_drive_enable(v_en), .vert_out_select(v_sel),
    .vertical_sync_pulse(vs), .field_indicator(fi),
    .field_sequence_indicator(fsq), .vertical_in_sync(v_sync),
    .raster_ctrl_horizontal_pin_in(h_oe ? h_out : h_ext),
    .raster_ctrl_horizontal_pin_out(h_out),
    .raster_ctrl_horizontal_pin_oe(h_oe), .horz_drive_enable(h_en),
    .hsync_length(h_len), .line_start(line_start),
    .horizontal_in_sync(h_sync), .bus_address_select(strap),
    .slave_address(saddr), .start_detected(start),
    .bus_wait_start(wait_st), .realtime_control_input(rt_in),
    .realtime_control_sync(rt_sync));
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wrap_up;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  // reset with both drive enables up: the pins must still stay inputs
  task automatic t_reset;
    @(negedge sys_clk);
    reset_n = 0;
    // the source restarts from its first pair, so stop it and rewind
    count = 8'h00;
    j = 0;
    v_en = 1;
    h_en = 1;
    repeat (8) @(negedge sys_clk);
    chk("v_oe in reset", 8'h00, 8'(v_oe));
    chk("h_oe in reset", 8'h00, 8'(h_oe));
    reset_n = 1;
    v_en = 0;
    h_en = 0;
    repeat (4) @(negedge sys_clk);
    chk("v_oe after", 8'h00, 8'(v_oe));
    chk("h_oe after", 8'h00, 8'(h_oe));
    chk("bus_wait_start", 8'h01, 8'(wait_st));
    chk("out_valid", 8'h00, 8'(ovalid));
    chk("pixel_ready", 8'h01, 8'(pready));
    chk("slave_address", strap ? 8'h8C : 8'h88, saddr);
    $display("test reset done, strap %0d", strap);
  endtask : t_reset
  // burst of n pairs; sink stalls the first stall cycles to fill buffer
  task automatic t_stream(input logic a, input logic b, input int n,
                          input int stall);
    int got;
    got = 0;
    sel_a = a;
    sel_b = b;
    count = count + 8'(n);
    for (int i = 0; i < 200 && got < n; i++) begin
      @(negedge sys_clk);
      oready = (i >= stall);
      if (stall > 0 && i == stall) begin
        chk("ready when full", 8'h00, 8'(pready));
      end
      if (ovalid === 1'b1 && oready) begin
        chk("enc_byte", a ? 8'hA0 + 8'(j) : 8'h10 + 8'(j), enc);
        chk("rgb_byte", b ? 8'h10 + 8'(j) : 8'hA0 + 8'(j), rgb);
        j++;
        got++;
      end
    end
    // let the last accepted pair pop before the sink lets go
    @(negedge sys_clk);
    oready = 0;
    if (got < n) begin
      miscompares++;
      $display("BAD pairs expected %0d seen %0d", n, got);
      wrap_up();
    end
    $display("test stream a %0d b %0d done", a, b);
  endtask : t_stream
  // second line_start lands inside the pulse and must not stretch it
  task automatic t_hsync(input logic [7:0] len);
    @(negedge sys_clk);
    h_en = 1;
    line_start = 1;
    h_len = len;
    cnt = 8'h00;
    @(negedge sys_clk);
    chk("h_oe driving", 8'h01, 8'(h_oe));
    for (int i = 0; i < 10; i++) begin
      if (h_out === 1'b1) cnt++;
      if (i == 1) line_start = 0;
      @(negedge sys_clk);
    end
    chk("hsync cycles", len, cnt);
    h_en = 0;
    $display("test hsync length %0d done", len);
  endtask : t_hsync
  task automatic t_vert;
    logic [3:0] pat;
    v_en = 1;
    for (int p = 0; p < 2; p++) begin
      {fsq, fi, vs} = p ? 3'h2 : 3'h5;
      pat = {1'b0, fsq, fi, vs};
      for (int s = 0; s < 4; s++) begin
        v_sel = 2'(s);
        repeat (2) @(negedge sys_clk);
        chk("vert out", 8'(pat[s]), 8'(v_out));
        chk("vert oe", 8'h01, 8'(v_oe));
      end
    end
    v_en = 0;
    v_ext = 1;
    h_ext = 1;
    rt_in = 1;
    repeat (4) @(negedge sys_clk);
    chk("vert released", 8'h00, 8'(v_oe));
    chk("vertical_in_sync", 8'h01, 8'(v_sync));
    chk("horizontal_in_sync", 8'h01, 8'(h_sync));
    chk("realtime sync", 8'h01, 8'(rt_sync));
    $display("test raster pins done");
  endtask : t_vert
  // a start seen with the clock enable low must not clear the wait
  task automatic t_start;
    @(negedge sys_clk);
    run = 0;
    start = 1;
    @(negedge sys_clk);
    start = 0;
    @(negedge sys_clk);
    chk("wait frozen", 8'h01, 8'(wait_st));
    run = 1;
    start = 1;
    @(negedge sys_clk);
    start = 0;
    @(negedge sys_clk);
    chk("wait cleared", 8'h00, 8'(wait_st));
    $display("test start done");
  endtask : t_start
  initial begin
    t_reset();
    t_stream(0, 0, 5, 0);
    t_stream(1, 1, 4, 8);
    t_stream(1, 0, 3, 0);
    t_stream(0, 1, 3, 0);
    t_hsync(8'h03);
    t_hsync(8'h01);
    t_hsync(8'h00);
    t_vert();
    t_start();
    strap = 1;
    t_reset();
    wrap_up();
  end
endmodule : dual_edge_video_input_port_tb
